// ### logic/ttc_pkg.sv
// Shared constants for the triggered trace capture unit
package ttc_pkg;

  // ----------------------------------------------------------------
  // Bus and sample geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int OBJ_NUM = 6;
  localparam int SAMP_W  = 64;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_OBJ0      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OBJ_STEP  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INTERVAL  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PRETRIG   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CAPLEN    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_TRIGMODE  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_TRIGSEL   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_THRESHOLD = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_OPTIONS   = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_READIDX   = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_DATA_LO   = 8'h3C;
  localparam logic [ADDR_W-1:0] OFF_DATA_HI   = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_RECLEN    = 8'h44;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int TRIG_DIR_BIT  = 0;
  localparam int TRIG_ABS_BIT  = 1;
  localparam int TRIG_MASK_BIT = 2;
  localparam int TRIG_BOTH_BIT = 3;
  localparam int OPT_SINGLE_BIT = 0;
  localparam int OBJ_LEN_LSB   = 0;
  localparam int OBJ_LEN_W     = 8;
  localparam logic [15:0] PRETRIG_FREE = 16'hFFFF;
  localparam logic [7:0]  CTRL_STOP    = 8'h00;

  // Reset values
  localparam logic [15:0] INTERVAL_RST = 16'h0001;
  localparam logic [15:0] CAPLEN_RST   = 16'h0001;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  // State codes as software reads them
  localparam logic [7:0] CODE_IDLE = 8'h00;
  localparam logic [7:0] CODE_PRE  = 8'h01;
  localparam logic [7:0] CODE_FREE = 8'h02;
  localparam logic [7:0] CODE_POST = 8'h03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real BASE_TICK_US = 62.5;
  localparam real REF_CLK_MHZ  = 20.0;
  localparam int  BASE_TICK_CYCLES = int'(BASE_TICK_US * REF_CLK_MHZ);

  // Gray along idle, pre, post; free-running off the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_POST = 2'b11,
    ST_FREE = 2'b10
  } ttc_state_type;

endpackage : ttc_pkg

// ### logic/ttc_capture_mem.sv
// Sample memory of the trace capture unit with registered read port
module ttc_capture_mem #(
  parameter int WIDTH  = 64,
  parameter int ADDR_W = 10
) (
  // Clock
  input  wire logic              ref_clk,
  // Write side
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  // Read side
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [WIDTH-1:0]  rdData
);

  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : ttc_capture_mem

// ### logic/ttc_trace_capture.sv
// Triggered trace capture unit: sampling, trigger and record readout
// What this block does
// - Take one sample every programmed number of 62.5 us base ticks.
// - Collect the programmed sample count, at most the memory depth; single mode then stops filling memory.
// - Keep the programmed pre-trigger length of samples from before the trigger.
// - Pre-trigger length of minus one means run until software stops it.
// - In that mode keep watching, store on trigger, then watch again.
// - Edge bit 0 picks falling (0) or rising (1) crossing.
// - Edge bit 1 picks signed (0) or absolute-value (1) comparison.
// - Edge bit 2 ANDs trigger object with the mask object first.
// - Trigger may also fire on both rising and falling crossings.
// - Capture starts when trigger object crosses threshold in raw units.
// - Each sample packs selected objects into at most 64 bits.
// - Single mode captures once except in free-running mode, which ignores it; otherwise capture repeats per trigger.
// - State 0 is idle; only then is the record offered for readout.
// - State 1 fills pre-trigger history while waiting for the trigger.
// - State 2 runs until software stops it, storing one record of the sample count on each trigger that comes while no record is being collected.
// - State 3 stores post-trigger samples, then returns to idle in single mode, otherwise to state 1.
// - The last record stays readable without a new capture.
//
// Design decisions made here: the register addresses and strobed register access.
module ttc_trace_capture
  import ttc_pkg::*;
#(
  parameter int MEM_ADDR_W = 10
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  // Register port
  input  wire logic [ttc_pkg::ADDR_W-1:0]            regAddr,
  input  wire logic [ttc_pkg::DATA_W-1:0]            regWrData,
  input  wire logic                                  regWrStb,
  input  wire logic                                  regRdStb,
  output logic      [ttc_pkg::DATA_W-1:0]            regRdData,
  // Object values from the drive, in the same clock domain
  input  wire logic [ttc_pkg::OBJ_NUM-1:0][31:0]     objValue,
  input  wire logic [31:0]                           trigValue,
  input  wire logic [31:0]                           maskValue,
  // Object selections handed to the object lookup
  output logic      [ttc_pkg::OBJ_NUM-1:0][31:0]     objSelect,
  output logic      [31:0]                           trigSelect
);

  import ttc_pkg::*;

  // ----------------------------------------------------------------
  // Local constants and helpers
  // ----------------------------------------------------------------
  localparam int TICK_W = $clog2(BASE_TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BASE_TICK_CYCLES - 1);
  localparam logic [15:0] DEPTH16 = 16'(1 << MEM_ADDR_W);

  function automatic logic [7:0] stateCode(input ttc_state_type s);
    case (s)
      ST_IDLE: stateCode = CODE_IDLE;
      ST_PRE:  stateCode = CODE_PRE;
      ST_FREE: stateCode = CODE_FREE;
      ST_POST: stateCode = CODE_POST;
      default: stateCode = CODE_IDLE;
    endcase
  endfunction : stateCode

  // Objects packed in order; one that would overflow 64 bits is skipped
  function automatic logic [SAMP_W-1:0] packSample(
    input logic [OBJ_NUM-1:0][31:0] sel,
    input logic [OBJ_NUM-1:0][31:0] val);
    logic [SAMP_W-1:0] acc;
    logic [7:0]        len;
    int                used;
    acc  = '0;
    used = 0;
    for (int i = 0; i < OBJ_NUM; i++)
    begin
      len = sel[i][OBJ_LEN_LSB +: OBJ_LEN_W];
      if (len != 8'h00 && len <= 8'h20 && used + int'(len) <= SAMP_W)
      begin
        acc  = (acc << len) |
               SAMP_W'(val[i] & (32'hFFFF_FFFF >> (6'd32 - 6'(len))));
        used = used + int'(len);
      end
    end
    packSample = acc;
  endfunction : packSample

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [OBJ_NUM-1:0][31:0] objSelReg;
  logic [15:0]              intervalReg;
  logic [15:0]              pretrigReg;
  logic [15:0]              capLenReg;
  logic [7:0]               trigModeReg;
  logic [31:0]              trigSelReg;
  logic [31:0]              thresholdReg;
  logic                     singleReg;
  logic [15:0]              readIdxReg;
  logic [DATA_W-1:0]        regRdDataReg;

  wire logic wrInterval  = regWrStb && regAddr == OFF_INTERVAL;
  wire logic wrPretrig   = regWrStb && regAddr == OFF_PRETRIG;
  wire logic wrCapLen    = regWrStb && regAddr == OFF_CAPLEN;
  wire logic wrTrigMode  = regWrStb && regAddr == OFF_TRIGMODE;
  wire logic wrTrigSel   = regWrStb && regAddr == OFF_TRIGSEL;
  wire logic wrThreshold = regWrStb && regAddr == OFF_THRESHOLD;
  wire logic wrOptions   = regWrStb && regAddr == OFF_OPTIONS;
  wire logic wrReadIdx   = regWrStb && regAddr == OFF_READIDX;
  wire logic wrCtrl      = regWrStb && regAddr == OFF_CTRL;
  wire logic stopCmd     = wrCtrl && regWrData[7:0] == CTRL_STOP;
  wire logic startCmd    = wrCtrl && regWrData[7:0] != CTRL_STOP;

  // Object select words, index:subindex:length, kept as written
  genvar gi;
  generate
    for (gi = 0; gi < OBJ_NUM; gi++)
    begin : g_obj
      wire logic wrObj = regWrStb &&
        regAddr == ADDR_W'(OFF_OBJ0 + OFF_OBJ_STEP * gi);
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          objSelReg[gi] <= ZERO32;
        else if (wrObj)
          objSelReg[gi] <= regWrData;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      intervalReg  <= INTERVAL_RST;
      pretrigReg   <= ZERO16;
      capLenReg    <= CAPLEN_RST;
      trigModeReg  <= 8'h00;
      trigSelReg   <= ZERO32;
      thresholdReg <= ZERO32;
      singleReg    <= 1'b1;
      readIdxReg   <= ZERO16;
    end
    else
    begin
      if (wrInterval)  intervalReg  <= regWrData[15:0];
      if (wrPretrig)   pretrigReg   <= regWrData[15:0];
      if (wrCapLen)    capLenReg    <= regWrData[15:0];
      if (wrTrigMode)  trigModeReg  <= regWrData[7:0];
      if (wrTrigSel)   trigSelReg   <= regWrData;
      if (wrThreshold) thresholdReg <= regWrData;
      if (wrOptions)   singleReg    <= regWrData[OPT_SINGLE_BIT];
      if (wrReadIdx)   readIdxReg   <= regWrData[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Sample timing
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickDivReg;
  logic              baseTickReg;
  logic [15:0]       intervalCntReg;
  ttc_state_type     stateReg;
  ttc_state_type     stateNext;

  // A zero interval would never sample, so it behaves as one
  wire logic [15:0] intervalEff = intervalReg == ZERO16 ? 16'h0001
                                                        : intervalReg;
  wire logic running = stateReg != ST_IDLE;
  wire logic sampleTick = running && baseTickReg &&
                          intervalCntReg >= intervalEff - 16'h0001;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tickDivReg  <= '0;
      baseTickReg <= 1'b0;
    end
    else
    begin
      tickDivReg  <= tickDivReg == TICK_LAST ? '0 : tickDivReg + 1'b1;
      baseTickReg <= tickDivReg == TICK_LAST;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      intervalCntReg <= ZERO16;
    else if (startCmd || sampleTick)
      intervalCntReg <= ZERO16;
    else if (running && baseTickReg)
      intervalCntReg <= intervalCntReg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Trigger evaluation
  // ----------------------------------------------------------------
  logic prevAboveReg;
  logic prevValidReg;

  wire logic [31:0] maskedVal = trigModeReg[TRIG_MASK_BIT]
                              ? trigValue & maskValue : trigValue;
  wire logic [31:0] cmpVal = trigModeReg[TRIG_ABS_BIT] && maskedVal[31]
                           ? 32'(-maskedVal) : maskedVal;
  wire logic curAbove = $signed(cmpVal) > $signed(thresholdReg);
  wire logic riseHit = prevValidReg && curAbove && !prevAboveReg;
  wire logic fallHit = prevValidReg && !curAbove && prevAboveReg;
  wire logic trigHit = trigModeReg[TRIG_BOTH_BIT] ? riseHit || fallHit
                     : trigModeReg[TRIG_DIR_BIT] ? riseHit
                     : fallHit;

  // History restarts at every start so an old level cannot fire
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prevAboveReg <= 1'b0;
      prevValidReg <= 1'b0;
    end
    else if (startCmd)
      prevValidReg <= 1'b0;
    else if (sampleTick)
    begin
      prevAboveReg <= curAbove;
      prevValidReg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------
  logic [MEM_ADDR_W-1:0] wrPtrReg, wrPtrNext;
  logic [MEM_ADDR_W-1:0] recStartReg, recStartNext;
  logic [15:0]           preCntReg, preCntNext;
  logic [15:0]           recLenReg, recLenNext;
  logic                  collectReg, collectNext;
  logic                  memWr;

  // Record never outgrows the memory; pre-trigger leaves room for one
  wire logic [15:0] capLenEff = capLenReg == ZERO16 ? 16'h0001
                              : capLenReg > DEPTH16 ? DEPTH16 : capLenReg;
  wire logic [15:0] preEff = pretrigReg >= capLenEff
                           ? capLenEff - 16'h0001 : pretrigReg;
  wire logic freeMode = pretrigReg == PRETRIG_FREE;
  wire logic preArmed = preCntReg >= preEff;
  wire logic lastPost = recLenReg + 16'h0001 >= capLenEff;
  wire logic firstLast = preCntReg + 16'h0001 >= capLenEff;
  wire ttc_state_type doneState = singleReg ? ST_IDLE : ST_PRE;

  always_comb
  begin
    stateNext    = stateReg;
    wrPtrNext    = wrPtrReg;
    recStartNext = recStartReg;
    preCntNext   = preCntReg;
    recLenNext   = recLenReg;
    collectNext  = collectReg;
    memWr        = 1'b0;
    if (stopCmd)
      stateNext = ST_IDLE;
    else if (startCmd)
    begin
      stateNext   = freeMode ? ST_FREE : ST_PRE;
      preCntNext  = ZERO16;
      recLenNext  = ZERO16;
      collectNext = 1'b0;
    end
    else if (sampleTick)
    begin
      case (stateReg)
        ST_PRE:
        begin
          memWr     = 1'b1;
          wrPtrNext = wrPtrReg + 1'b1;
          if (trigHit && preArmed)
          begin
            recStartNext = wrPtrReg - MEM_ADDR_W'(preCntReg);
            recLenNext   = preCntReg + 16'h0001;
            stateNext    = firstLast ? doneState : ST_POST;
            preCntNext   = ZERO16;
          end
          else if (!preArmed)
            preCntNext = preCntReg + 16'h0001;
        end
        ST_POST:
        begin
          memWr      = 1'b1;
          wrPtrNext  = wrPtrReg + 1'b1;
          recLenNext = recLenReg + 16'h0001;
          if (lastPost)
            stateNext = doneState;
        end
        ST_FREE:
        begin
          if (collectReg)
          begin
            memWr      = 1'b1;
            wrPtrNext  = wrPtrReg + 1'b1;
            recLenNext = recLenReg + 16'h0001;
            if (lastPost)
              collectNext = 1'b0;
          end
          else if (trigHit)
          begin
            memWr        = 1'b1;
            wrPtrNext    = wrPtrReg + 1'b1;
            recStartNext = wrPtrReg;
            recLenNext   = 16'h0001;
            collectNext  = capLenEff > 16'h0001;
          end
        end
        default: stateNext = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg    <= ST_IDLE;
      wrPtrReg    <= '0;
      recStartReg <= '0;
      preCntReg   <= ZERO16;
      recLenReg   <= ZERO16;
      collectReg  <= 1'b0;
    end
    else
    begin
      stateReg    <= stateNext;
      wrPtrReg    <= wrPtrNext;
      recStartReg <= recStartNext;
      preCntReg   <= preCntNext;
      recLenReg   <= recLenNext;
      collectReg  <= collectNext;
    end
  end

  // ----------------------------------------------------------------
  // Sample memory and readout
  // ----------------------------------------------------------------
  logic [SAMP_W-1:0] memRdData;
  wire logic [SAMP_W-1:0] sampleWord = packSample(objSelReg, objValue);
  wire logic [MEM_ADDR_W-1:0] rdAddr =
    recStartReg + readIdxReg[MEM_ADDR_W-1:0];
  wire logic idle = stateReg == ST_IDLE;

  ttc_capture_mem #(
    .WIDTH  (SAMP_W),
    .ADDR_W (MEM_ADDR_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .wrEn    (memWr),
    .wrAddr  (wrPtrReg),
    .wrData  (sampleWord),
    .rdAddr  (rdAddr),
    .rdData  (memRdData)
  );

  logic [DATA_W-1:0] rdMux;

  // Captured words read as zero outside idle; the record is kept
  always_comb
  begin
    rdMux = ZERO32;
    if (regAddr >= OFF_OBJ0 && regAddr < OFF_CTRL)
      rdMux = objSelReg[(regAddr - OFF_OBJ0) >> 2];
    else
      case (regAddr)
        OFF_CTRL:      rdMux = {24'h00_0000, stateCode(stateReg)};
        OFF_INTERVAL:  rdMux = {16'h0000, intervalReg};
        OFF_PRETRIG:   rdMux = {16'h0000, pretrigReg};
        OFF_CAPLEN:    rdMux = {16'h0000, capLenReg};
        OFF_TRIGMODE:  rdMux = {24'h00_0000, trigModeReg};
        OFF_TRIGSEL:   rdMux = trigSelReg;
        OFF_THRESHOLD: rdMux = thresholdReg;
        OFF_OPTIONS:   rdMux = {31'h0000_0000, singleReg};
        OFF_READIDX:   rdMux = {16'h0000, readIdxReg};
        OFF_DATA_LO:   rdMux = idle ? memRdData[31:0] : ZERO32;
        OFF_DATA_HI:   rdMux = idle ? memRdData[63:32] : ZERO32;
        OFF_RECLEN:    rdMux = {16'h0000, recLenReg};
        default:       rdMux = ZERO32;
      endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      regRdDataReg <= ZERO32;
    else
      regRdDataReg <= regRdStb ? rdMux : ZERO32;
  end

  assign regRdData  = regRdDataReg;
  assign objSelect  = objSelReg;
  assign trigSelect = trigSelReg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sample_on_tick_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    memWr |-> running && tickDivReg == '0 && $past(tickDivReg) == TICK_LAST)
    else $error("sample written off the base tick");

  tick_spacing_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    baseTickReg |=> !baseTickReg [*8])
    else $error("base ticks too close together");

  stop_at_len_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stateReg == ST_POST && sampleTick && lastPost && !wrCtrl
    |=> stateReg != ST_POST)
    else $error("post phase ran past the sample count");

  pre_history_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stateReg == ST_PRE && sampleTick && trigHit && preArmed && !wrCtrl
    |=> recLenReg == $past(preCntReg) + 16'h0001)
    else $error("pre-trigger history not kept");

  free_start_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    startCmd && freeMode |=> stateReg == ST_FREE ##1
      ($past(wrCtrl) || stateReg == ST_FREE))
    else $error("free-running start failed");

  pre_start_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    startCmd && !freeMode |=> stateReg == ST_PRE)
    else $error("bounded start did not enter pre-trigger");

  repeat_rearm_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stateReg == ST_POST && sampleTick && lastPost && !singleReg && !wrCtrl
    |=> stateReg == ST_PRE && preCntReg == ZERO16)
    else $error("repeat mode did not re-arm");

  single_idle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stateReg == ST_POST && sampleTick && lastPost && singleReg && !wrCtrl
    |=> idle)
    else $error("single capture did not return to idle");

  readout_idle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    regRdStb && !idle && regAddr == OFF_DATA_LO |=> regRdData == ZERO32)
    else $error("record offered while not idle");

  stop_cmd_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    stopCmd |=> idle)
    else $error("stop did not reach idle");

endmodule : ttc_trace_capture

// ### verification/ttc_drive_model.sv
// Drive-side object source feeding the trace capture unit
module ttc_drive_model
  import ttc_pkg::*;
(
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  // Test controls
  input  wire logic                              trigNeg,
  input  wire logic                              maskZero,
  // Objects to the unit
  output logic      [ttc_pkg::OBJ_NUM-1:0][31:0] objValue,
  output logic      [31:0]                       trigValue,
  output logic      [31:0]                       maskValue,
  // Bench view
  output logic      [31:0]                       seqNow,
  output logic      [15:0]                       phase
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Values step mid-tick, so a sample never sees a half-changed value
  // ----
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase  <= 16'h0000;
      seqNow <= 32'h0000_0000;
    end
    else
    begin
      phase <= (phase == BASE_TICK_CYCLES - 1) ? 16'h0000 : phase + 1'b1;
      if (phase == BASE_TICK_CYCLES / 2)
        seqNow <= seqNow + 1'b1;
    end
  end
  always_comb
  begin
    objValue    = '0;
    objValue[0] = seqNow;
    objValue[1] = ~seqNow;
  end
  assign trigValue = trigNeg ? -seqNow : seqNow;
  assign maskValue = maskZero ? 32'h0000_0000 : 32'hFFFF_FFFF;
endmodule : ttc_drive_model

// ### verification/ttc_trace_capture_tb.sv
// Self-checking bench for the triggered trace capture unit
module ttc_trace_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ttc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} ttc_row_type;
  logic ref_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0;
  logic trigNeg = 0, maskZero = 0;
  logic [7:0]  regAddr = '0;
  logic [31:0] regWrData = '0, regRdData, trigValue, maskValue, seqNow, rdv;
  logic [OBJ_NUM-1:0][31:0] objValue, objSelect;
  logic [31:0] trigSelect;
  logic [15:0] phase;
  logic [31:0] trigAt;
  int errorCnt = 0, nChecks = 0;
  ttc_row_type rows [6] = '{'{OFF_OBJ0, 32'h1234_0020, 32'h1234_0020},
    '{OFF_OBJ_STEP, 32'h5678_0020, 32'h5678_0020},
    '{OFF_TRIGSEL, 32'h2000_0010, 32'h2000_0010},
    '{OFF_THRESHOLD, 32'h8000_0001, 32'h8000_0001},
    '{OFF_INTERVAL, 32'h0000_0003, 32'h0000_0003},
    '{8'h50, 32'hFFFF_FFFF, 32'h0000_0000}};
  ttc_row_type rstRows [6] = '{'{OFF_CTRL, 0, 0}, '{OFF_INTERVAL, 0, 1},
    '{OFF_PRETRIG, 0, 0}, '{OFF_CAPLEN, 0, 1}, '{OFF_OPTIONS, 0, 1},
    '{OFF_THRESHOLD, 0, 0}};

  ttc_trace_capture #(.MEM_ADDR_W(4)) dut (.ref_clk, .rst, .regAddr,
    .regWrData, .regWrStb, .regRdStb, .regRdData, .objValue, .trigValue,
    .maskValue, .objSelect, .trigSelect);
  ttc_drive_model model (.ref_clk, .rst, .trigNeg, .maskZero, .objValue,
    .trigValue, .maskValue, .seqNow, .phase);

  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  // ----
  // Bus and compare tasks
  // ----
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge ref_clk);
    regWrStb  <= 1'b0;
  endtask : wr
  // Read data stand for one cycle only, so they are taken mid-cycle
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask : rd
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, rdv);
    chk(nm, e, rdv);
  endtask : rdchk
  // Start near a tick boundary so the sample phase cannot straddle a step
  task start(input logic [7:0] mode, input logic [31:0] thr);
    wr(OFF_TRIGMODE, {24'h0, mode});
    wr(OFF_THRESHOLD, thr);
    while (phase !== 16'h0000)
      @(posedge ref_clk);
    wr(OFF_CTRL, 32'h0000_0001);
  endtask : start
  task run(input logic [7:0] mode, input logic neg, input int lead,
           input string nm);
    logic [31:0] base;
    logic [31:0] s;
    trigNeg <= neg;
    base = seqNow + 4;
    wr(OFF_PRETRIG, 32'h0000_0001);
    start(mode, (neg && !mode[1]) ? -base : base);
    repeat (40)
    begin
      repeat (500) @(posedge ref_clk);
      rd(OFF_CTRL, rdv);
      chk("poll", 32'h0000_0000, rdv & 32'hFFFF_FFFC);
      if (rdv === 32'h0000_0000)
        break;
    end
    rdchk(OFF_CTRL, CODE_IDLE, "state");
    rdchk(OFF_RECLEN, 32'h0000_0003, "reclen");
    for (int k = 0; k < 3; k++)
    begin
      s = base + lead - 1 + k;
      wr(OFF_READIDX, k);
      rdchk(OFF_DATA_HI, s, "hi");
      rdchk(OFF_DATA_LO, ~s, "lo");
    end
    rdchk(OFF_DATA_HI, s, "reread");
    $display("Test %s done", nm);
  endtask : run
  task complete_run;
    $display("Checks %0d, errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    #(90000 * 50);
    errorCnt++;
    $display("[ERR] watchdog expected finish seen hang");
    complete_run();
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e, "reg");
    end
    chk("objSelect1", 32'h5678_0020, objSelect[1]);
    chk("trigSelect", 32'h2000_0010, trigSelect);
    $display("Test registers done");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rstRows[i])
      rdchk(rstRows[i].a, rstRows[i].e, "reset");
    chk("objSelect0", 32'h0000_0000, objSelect[0]);
    $display("Test reset done");
    wr(OFF_OBJ0, 32'h0000_0020);
    wr(OFF_OBJ_STEP, 32'h0000_0020);
    wr(OFF_CAPLEN, 32'h0000_0003);
    run(8'h01, 1'b0, 1, "rising");
    repeat (2600) @(posedge ref_clk);
    rdchk(OFF_CTRL, CODE_IDLE, "single");
    run(8'h00, 1'b1, 0, "falling");
    run(8'h03, 1'b1, 1, "absolute");
    run(8'h08, 1'b0, 1, "both");
    wr(OFF_OPTIONS, 32'h0000_0000);
    start(8'h01, seqNow + 2);
    repeat (7500) @(posedge ref_clk);
    rdchk(OFF_CTRL, CODE_PRE, "rearm");
    rdchk(OFF_RECLEN, 32'h0000_0003, "rearm len");
    $display("Test repeat done");
    trigNeg  <= 1'b0;
    wr(OFF_PRETRIG, {16'h0, PRETRIG_FREE});
    trigAt = seqNow + 3;
    start(8'h01, seqNow + 2);
    repeat (7500) @(posedge ref_clk);
    rdchk(OFF_CTRL, CODE_FREE, "free");
    wr(OFF_CTRL, {24'h0, CTRL_STOP});
    rdchk(OFF_RECLEN, 32'h0000_0003, "free len");
    wr(OFF_READIDX, 32'h0000_0000);
    rdchk(OFF_DATA_HI, trigAt, "free data");
    maskZero <= 1'b1;
    wr(OFF_PRETRIG, 32'h0000_0001);
    start(8'h05, seqNow + 2);
    repeat (7500) @(posedge ref_clk);
    rdchk(OFF_CTRL, CODE_PRE, "masked");
    rdchk(OFF_DATA_HI, 32'h0000_0000, "busy data");
    wr(OFF_CTRL, {24'h0, CTRL_STOP});
    rdchk(OFF_CTRL, CODE_IDLE, "stop");
    $display("Test mask and stop done");
    complete_run();
  end
endmodule : ttc_trace_capture_tb
